//--- design/rlru_pkg.sv
// Purpose: shared constants for the rotate left/right unit
// Assumes: 8-bit datapath, four quarter phases per instruction cycle
// Notes:   APB map and field positions live here
package rlru_pkg;
  // ==========================================================
  // data and addressing
  localparam int unsigned        RLRU_DW          = 8;
  localparam int unsigned        RLRU_MSB         = 7;
  localparam int unsigned        RLRU_LSB         = 0;
  localparam logic [7:0]         RLRU_ILO_MAX     = 8'h5F;
  localparam logic               RLRU_DEST_ACC    = 1'b0;
  localparam logic               RLRU_BANK_ACCESS = 1'b0;
  // ==========================================================
  // register map (byte addresses, 32-bit words)
  localparam logic [7:0]  RLRU_OFF_CTRL   = 8'h00;
  localparam logic [7:0]  RLRU_OFF_STATUS = 8'h04;
  localparam logic [7:0]  RLRU_OFF_ACC    = 8'h08;
  localparam logic [7:0]  RLRU_OFF_BANK   = 8'h0C;
  // ctrl fields
  localparam int unsigned RLRU_CTRL_EXT   = 0;
  // status fields
  localparam int unsigned RLRU_ST_C       = 0;
  localparam int unsigned RLRU_ST_Z       = 1;
  localparam int unsigned RLRU_ST_N       = 2;
  localparam int unsigned RLRU_ST_BUSY    = 3;
  // reset values
  localparam logic [7:0]  RLRU_ACC_RST    = 8'h00;
  localparam logic [3:0]  RLRU_BANK_RST   = 4'h0;
  localparam logic        RLRU_EXT_RST    = 1'b0;
  localparam logic [31:0] RLRU_UNMAPPED   = 32'h00000000;
  // ==========================================================
  // types
  typedef enum logic [1:0] {RLRU_Q1, RLRU_Q2, RLRU_Q3, RLRU_Q4} rlru_q_t;
  typedef enum logic {RLRU_OP_RLNC, RLRU_OP_RRC} rlru_op_t;
endpackage

//--- design/rlru_rotator.sv
// Purpose: combinational rotate core
// Assumes: 8-bit operand, carry as ninth bit for right rotate
// Notes:   zero and negative flags computed from the result; carry from operand bit 0 or passed through
`timescale 1ns/1ps
`default_nettype none
module rlru_rotator
  import rlru_pkg::*;
(
  // operation
  input  wire rlru_pkg::rlru_op_t i_op,
  input  wire logic [7:0]         i_val,
  input  wire logic               i_carry,
  // result
  output logic [7:0]              o_res,
  output logic                    o_carry,
  output logic                    o_neg,
  output logic                    o_zero
);
  always_comb
  begin
    if (i_op == RLRU_OP_RLNC)
    begin
      o_res   = {i_val[RLRU_MSB-1:0], i_val[RLRU_MSB]};
      o_carry = i_carry;
    end
    else
    begin
      o_res   = {i_carry, i_val[RLRU_MSB:1]};
      o_carry = i_val[RLRU_LSB];
    end
    o_neg  = o_res[RLRU_MSB];
    o_zero = (o_res == 8'h00);
  end
endmodule
`default_nettype wire

//--- design/rlru_top.sv
// Purpose: rotate path of an 8-bit datapath, quarter-phase sequenced
// Assumes: decoder holds the request until o_done; register file answers reads in Q2
// Notes:   accumulator, carry and flags are local; APB reaches control and status
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rlru_top
  import rlru_pkg::*;
(
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_sys_rst,
  // decoder request
  input  wire logic               i_start,
  input  wire rlru_pkg::rlru_op_t i_op,
  input  wire logic [7:0]         i_faddr,
  input  wire logic               i_dest,
  input  wire logic               i_bank,
  output logic                    o_done,
  // register file
  output logic                    o_rd_en,
  output logic [7:0]              o_rd_addr,
  output logic [3:0]              o_rd_bank,
  output logic                    o_rd_access,
  output logic                    o_rd_indexed,
  input  wire logic [7:0]         i_rd_data,
  output logic                    o_wr_en,
  output logic [7:0]              o_wr_data,
  // apb
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr
);
  import rlru_pkg::*;

  // ==========================================================
  // state
  rlru_q_t    q_ff;
  logic       busy_ff;
  logic [7:0] opnd_ff, res_ff, acc_ff;
  logic       c_ff, n_ff, z_ff, ext_ff;
  logic [3:0] bank_ff;
  logic [7:0] rot_res;
  logic       rot_c, rot_n, rot_z;
  logic       apb_wr;

  function automatic logic is_indexed(input logic ext, input logic bank, input logic [7:0] a);
    is_indexed = ext && (bank == RLRU_BANK_ACCESS) && (a <= RLRU_ILO_MAX);
  endfunction

  // ==========================================================
  // quarter phase sequencer
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      q_ff    <= RLRU_Q1;
      busy_ff <= 1'b0;
    end
    else if (!busy_ff)
    begin
      if (i_start)
      begin
        busy_ff <= 1'b1;
        q_ff    <= RLRU_Q2;
      end
    end
    else
    begin
      unique case (q_ff)
        RLRU_Q1: q_ff <= RLRU_Q2;
        RLRU_Q2: q_ff <= RLRU_Q3;
        RLRU_Q3: q_ff <= RLRU_Q4;
        RLRU_Q4:
        begin
          q_ff    <= RLRU_Q1;
          busy_ff <= 1'b0;
        end
      endcase
    end
  end

  // operand address outputs; decoder holds the request fields
  assign o_rd_en      = busy_ff && (q_ff == RLRU_Q2);
  assign o_rd_addr    = i_faddr;
  assign o_rd_bank    = bank_ff;
  assign o_rd_access  = (i_bank == RLRU_BANK_ACCESS);
  assign o_rd_indexed = is_indexed(ext_ff, i_bank, i_faddr);
  assign o_done       = busy_ff && (q_ff == RLRU_Q4);

  // ==========================================================
  // datapath
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      opnd_ff <= 8'h00;
      res_ff  <= 8'h00;
    end
    else
    begin
      if (o_rd_en)
        opnd_ff <= i_rd_data;
      if (busy_ff && (q_ff == RLRU_Q3))
        res_ff <= rot_res;
    end
  end

  rlru_rotator u_rot (
    .i_op    (i_op),
    .i_val   (opnd_ff),
    .i_carry (c_ff),
    .o_res   (rot_res),
    .o_carry (rot_c),
    .o_neg   (rot_n),
    .o_zero  (rot_z)
  );

  // flags latched in Q3, visible together with result in Q4
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      c_ff <= 1'b0;
      n_ff <= 1'b0;
      z_ff <= 1'b0;
    end
    else if (busy_ff && (q_ff == RLRU_Q3))
    begin
      c_ff <= rot_c;
      n_ff <= rot_n;
      z_ff <= rot_z;
    end
  end

  // destination write in Q4
  assign o_wr_en   = o_done && (i_dest != RLRU_DEST_ACC);
  assign o_wr_data = res_ff;

  assign apb_wr = psel && penable && pwrite;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      acc_ff <= RLRU_ACC_RST;
    else if (o_done && (i_dest == RLRU_DEST_ACC))
      acc_ff <= res_ff;
    else if (apb_wr && paddr == RLRU_OFF_ACC)
      acc_ff <= pwdata[7:0];
  end

  // ==========================================================
  // apb slave: zero wait state, unmapped reads zero without error
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      ext_ff  <= RLRU_EXT_RST;
      bank_ff <= RLRU_BANK_RST;
    end
    else if (apb_wr)
    begin
      if (paddr == RLRU_OFF_CTRL)
        ext_ff <= pwdata[RLRU_CTRL_EXT];
      if (paddr == RLRU_OFF_BANK)
        bank_ff <= pwdata[3:0];
    end
  end

  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_comb
  begin
    prdata = RLRU_UNMAPPED;
    unique case (paddr)
      RLRU_OFF_CTRL:   prdata[RLRU_CTRL_EXT] = ext_ff;
      RLRU_OFF_STATUS:
      begin
        prdata[RLRU_ST_C]    = c_ff;
        prdata[RLRU_ST_Z]    = z_ff;
        prdata[RLRU_ST_N]    = n_ff;
        prdata[RLRU_ST_BUSY] = busy_ff;
      end
      RLRU_OFF_ACC:    prdata[7:0] = acc_ff;
      RLRU_OFF_BANK:   prdata[3:0] = bank_ff;
      default:         prdata = RLRU_UNMAPPED;
    endcase
  end

  // ==========================================================
  // checks
  sequence s_start;
    !busy_ff && i_start;
  endsequence

  property p_cycle_len;
    @(posedge i_clk) disable iff (i_sys_rst) s_start |-> ##3 o_done;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("rotate not done in Q4");

  property p_rl;
    @(posedge i_clk) disable iff (i_sys_rst)
      (o_done && i_op == RLRU_OP_RLNC) |-> res_ff == {opnd_ff[6:0], opnd_ff[7]};
  endproperty
  a_rl: assert property (p_rl) else $error("left rotate wrong");

  property p_rl_carry;
    @(posedge i_clk) disable iff (i_sys_rst)
      (busy_ff && q_ff == RLRU_Q3 && i_op == RLRU_OP_RLNC) |=> $stable(c_ff);
  endproperty
  a_rl_carry: assert property (p_rl_carry) else $error("left rotate touched carry");

  property p_rr;
    @(posedge i_clk) disable iff (i_sys_rst)
      (busy_ff && q_ff == RLRU_Q3 && i_op == RLRU_OP_RRC)
        |=> res_ff == {$past(c_ff), opnd_ff[7:1]} && c_ff == opnd_ff[0];
  endproperty
  a_rr: assert property (p_rr) else $error("right rotate wrong");

  property p_flags;
    @(posedge i_clk) disable iff (i_sys_rst)
      o_done |-> n_ff == res_ff[7] && z_ff == (res_ff == 8'h00);
  endproperty
  a_flags: assert property (p_flags) else $error("flags wrong");

  property p_dest;
    @(posedge i_clk) disable iff (i_sys_rst)
      (o_done && i_dest == RLRU_DEST_ACC) |=> acc_ff == $past(res_ff) && !$past(o_wr_en);
  endproperty
  a_dest: assert property (p_dest) else $error("accumulator not written");

  property p_index;
    @(posedge i_clk) disable iff (i_sys_rst)
      (o_rd_en && ext_ff && !i_bank && i_faddr <= RLRU_ILO_MAX) |-> o_rd_indexed && o_rd_access;
  endproperty
  a_index: assert property (p_index) else $error("indexed mode missed");

  property p_read_q2;
    @(posedge i_clk) disable iff (i_sys_rst) s_start |=> o_rd_en ##1 !o_rd_en;
  endproperty
  a_read_q2: assert property (p_read_q2) else $error("read not in Q2");
endmodule
`default_nettype wire

//--- tb/rlru_regfile_model.sv
// Purpose: register file stand-in on the far side of the rotate unit
// Assumes: read data is needed only while i_rd_en is high
// Notes:   shows inverted last data when not read, so stale sampling is caught
`timescale 1ns/1ps
`default_nettype none
module rlru_regfile_model
(
  // clock
  input  wire logic       i_clk,
  // read side
  input  wire logic       i_rd_en,
  input  wire logic [7:0] i_rd_addr,
  output logic [7:0]      o_rd_data,
  // write side
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_wr_data
);
  // ==========================================================
  // storage, preset by the bench through hierarchy
  logic [7:0] mem_ff [256];
  logic [7:0] last_ff;
  assign o_rd_data = i_rd_en ? mem_ff[i_rd_addr] : ~last_ff;
  always @(posedge i_clk)
  begin
    if (i_rd_en)
      last_ff <= mem_ff[i_rd_addr];
    // operand address is held through the write phase
    if (i_wr_en)
      mem_ff[i_rd_addr] <= i_wr_data;
  end
endmodule
`default_nettype wire

//--- tb/rotate_left_right_unit_bench.sv
// Purpose: self-checking bench for the rotate unit
// Assumes: apb answers with pready, decoder holds operands until done
// Notes:   carry flows from one rotate into the next, so case order matters
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module rotate_left_right_unit_bench;
  import rlru_pkg::*;
  logic        i_clk, i_sys_rst, i_start, i_dest, i_bank;
  rlru_op_t    i_op;
  logic [7:0]  i_faddr, rd_data, o_rd_addr, o_wr_data, paddr;
  logic [3:0]  o_rd_bank;
  logic        o_done, o_rd_en, o_rd_access, o_rd_indexed, o_wr_en;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata, rdv;
  int          n_mismatch, compares, k;
  rlru_top u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_start(i_start), .i_op(i_op),
    .i_faddr(i_faddr), .i_dest(i_dest), .i_bank(i_bank), .o_done(o_done), .o_rd_en(o_rd_en),
    .o_rd_addr(o_rd_addr), .o_rd_bank(o_rd_bank), .o_rd_access(o_rd_access),
    .o_rd_indexed(o_rd_indexed), .i_rd_data(rd_data), .o_wr_en(o_wr_en),
    .o_wr_data(o_wr_data), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  rlru_regfile_model u_rf (.i_clk(i_clk), .i_rd_en(o_rd_en), .i_rd_addr(o_rd_addr),
    .o_rd_data(rd_data), .i_wr_en(o_wr_en), .i_wr_data(o_wr_data));
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // ==========================================================
  // bus and instruction tasks
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1)
      @(posedge i_clk);
    rdv = prdata;
    `CHK("pslverr", 1'b0, pslverr)
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rot(input rlru_op_t op, input logic [7:0] a, input logic d, b,
                     input logic [7:0] v, r, input logic [2:0] nzc, input logic ix);
    int n;
    u_rf.mem_ff[a] = v;
    @(posedge i_clk);
    i_start <= 1'b1;
    i_op    <= op;
    i_faddr <= a;
    i_dest  <= d;
    i_bank  <= b;
    @(posedge i_clk);
    i_start <= 1'b0;
    for (n = 0; n < 4 && o_rd_en !== 1'b1; n++)
      @(negedge i_clk);
    `CHK("rd_en", 1'b1, o_rd_en)
    `CHK("rd_addr", a, o_rd_addr)
    `CHK("rd_access", ~b, o_rd_access)
    `CHK("rd_indexed", ix, o_rd_indexed)
    if (b) `CHK("rd_bank", 4'hA, o_rd_bank)
    repeat (2) @(negedge i_clk);
    `CHK("done", 1'b1, o_done)
    `CHK("wr_en", d, o_wr_en)
    if (d) `CHK("wr_data", r, o_wr_data)
    apb(1'b0, RLRU_OFF_STATUS, 32'h0);
    `CHK("flags", nzc, {rdv[RLRU_ST_N], rdv[RLRU_ST_Z], rdv[RLRU_ST_C]})
    apb(1'b0, RLRU_OFF_ACC, 32'h0);
    if (!d) `CHK("acc", r, rdv[7:0])
    else `CHK("regfile", r, u_rf.mem_ff[a])
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // watchdog, far beyond the roughly one hundred cycles the tests need
  initial
  begin
    repeat (3000) @(posedge i_clk);
    n_mismatch++;
    tally_and_finish();
  end
  // ==========================================================
  // tests
  initial
  begin
    {i_sys_rst, i_start, i_dest, i_bank, psel, penable, pwrite} = 7'h41;
    i_op = RLRU_OP_RLNC;
    {i_faddr, paddr, pwdata} = '0;
    n_mismatch = 0;
    compares = 0;
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    // every word, the unmapped one included, reads zero after reset
    for (k = 0; k < 5; k++)
    begin
      apb(1'b0, 8'(k * 4), 32'h0);
      `CHK("reset word", 32'h0, rdv)
    end
    apb(1'b1, RLRU_OFF_BANK, 32'h0000000A);
    apb(1'b0, RLRU_OFF_BANK, 32'h0);
    `CHK("bank reg", 4'hA, rdv[3:0])
    apb(1'b1, 8'h10, 32'h000000FF);
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", RLRU_UNMAPPED, rdv)
    apb(1'b1, RLRU_OFF_CTRL, 32'h00000001);
    apb(1'b0, RLRU_OFF_CTRL, 32'h0);
    `CHK("ctrl", 1'b1, rdv[RLRU_CTRL_EXT])
    $display("test registers finished");
    rot(RLRU_OP_RLNC, 8'h20, 1'b1, 1'b1, 8'hAB, 8'h57, 3'b000, 1'b0);
    rot(RLRU_OP_RRC, 8'h10, 1'b0, 1'b0, 8'hE6, 8'h73, 3'b000, 1'b1);
    rot(RLRU_OP_RRC, 8'h5F, 1'b0, 1'b0, 8'h01, 8'h00, 3'b011, 1'b1);
    rot(RLRU_OP_RLNC, 8'h60, 1'b1, 1'b0, 8'h80, 8'h01, 3'b001, 1'b0);
    rot(RLRU_OP_RRC, 8'h60, 1'b1, 1'b1, 8'h00, 8'h80, 3'b100, 1'b0);
    // preload a nonzero accumulator so the zero result below proves the write
    apb(1'b1, RLRU_OFF_ACC, 32'h0000005A);
    apb(1'b0, RLRU_OFF_ACC, 32'h0);
    `CHK("acc write", 8'h5A, rdv[7:0])
    rot(RLRU_OP_RLNC, 8'h30, 1'b0, 1'b1, 8'h00, 8'h00, 3'b010, 1'b0);
    $display("test rotates finished");
    tally_and_finish();
  end
endmodule
`default_nettype wire
